// [rdirq_regs.vh]
// register offsets, field positions, reset values and command codes of the radio irq/config bank
// Function
// - irq asserts when tx done, rx ready or retry flag sets and unmasked.
// - host writes one to a flag to clear; irq releases when none unmasked remain.
// - config bits 6,5,4 mask rx ready, tx done and retry limit sources.
// - all three mask bits read zero after reset.
// - interrupt line is active low while any unmasked flag is set.
// - status pipe field updates on irq falling edge; unreliable if read then.
// - host reaches the radio only by register read and write commands.
// - undefined register bits always read back as zero.
// - crc enable bit 3 resets one, forced by auto ack; bit 2 crc length.
// - bit 1 power on, bit 0 primary receiver select, both reset zero.
// - register 01 auto ack enables bits 5:0 reset one; bits 7:6 zero.
// - status shifts out on serial data output right after chip select falls.
`ifndef RDIRQ_REGS_VH
`define RDIRQ_REGS_VH
`define RDIRQ_ADDR_CONFIG 5'h00
`define RDIRQ_ADDR_AUTO_ACK 5'h01
`define RDIRQ_ADDR_RX_EN 5'h02
`define RDIRQ_ADDR_STATUS 5'h07
`define RDIRQ_CMD_WRITE_BIT 5
`define RDIRQ_CMD_OP_MSB 7
`define RDIRQ_CMD_OP_LSB 6
`define RDIRQ_CMD_OP_REG 2'h0
`define RDIRQ_BIT_MASK_RX 6
`define RDIRQ_BIT_MASK_TX 5
`define RDIRQ_BIT_MASK_RT 4
`define RDIRQ_BIT_CRC_EN 3
`define RDIRQ_BIT_CRC_LEN 2
`define RDIRQ_BIT_PWR 1
`define RDIRQ_BIT_PRIM 0
`define RDIRQ_BIT_RX_READY 6
`define RDIRQ_BIT_TX_DONE 5
`define RDIRQ_BIT_RETRY 4
`define RDIRQ_PIPE_MSB 3
`define RDIRQ_PIPE_LSB 1
`define RDIRQ_RST_MASKS 3'h0
`define RDIRQ_RST_CRC_EN 1'h1
`define RDIRQ_RST_CRC_LEN 1'h0
`define RDIRQ_RST_PWR 1'h0
`define RDIRQ_RST_PRIM 1'h0
`define RDIRQ_RST_AUTO_ACK 6'h3F
`define RDIRQ_RST_RX_EN 6'h03
`define RDIRQ_RST_PIPE 3'h7
`endif

// [rdirq_bank.v]
// radio interrupt flags and first configuration registers behind the serial register port
`timescale 1ns/1ps
`default_nettype none
`include "rdirq_regs.vh"
module rdirq_bank (
    input wire clock_i,
    input wire rstn_i,
    input wire ce_i,
    input wire chip_select_n_i,
    input wire spi_sck_i,
    input wire spi_mosi_i,
    output reg spi_miso_o,
    input wire tx_done_evt_i,
    input wire rx_ready_evt_i,
    input wire retry_limit_evt_i,
    input wire [2:0] rx_pipe_i,
    output reg radio_irq_n_o,
    output reg crc_enable_o,
    output reg crc_length_sel_o,
    output reg power_on_bit_o,
    output reg primary_role_sel_o,
    output reg [5:0] auto_ack_o,
    output reg [5:0] rx_enable_o
);
    // two-stage synchronisers plus one history stage for edge detection
    reg cs_s1_ff;
    reg cs_s2_ff;
    reg cs_s3_ff;
    reg sck_s1_ff;
    reg sck_s2_ff;
    reg sck_s3_ff;
    reg mosi_s1_ff;
    reg mosi_s2_ff;
    // serial engine: bit and byte position in the frame, the shift registers and
    // the command byte that steers the data byte
    reg [2:0] bit_cnt_ff;
    reg [1:0] byte_cnt_ff;
    reg [7:0] rx_sr_ff;
    reg [7:0] tx_sr_ff;
    reg [7:0] cmd_ff;
    // register state
    reg mask_rx_ready_ff;
    reg mask_tx_done_ff;
    reg mask_retry_limit_ff;
    reg crc_en_ff;
    reg crc_length_sel_ff;
    reg power_on_bit_ff;
    reg primary_role_sel_ff;
    reg [5:0] auto_ack_ff;
    reg [5:0] rx_enable_ff;
    reg rx_ready_flag_ff;
    reg tx_done_flag_ff;
    reg retry_limit_flag_ff;
    reg [2:0] pipe_ff;

    wire cs_fall;
    wire cs_active;
    wire sck_rise;
    wire sck_fall;
    wire [7:0] rx_byte;
    wire byte_done;
    wire wr_stb;
    wire [7:0] status_val;
    wire crc_en_eff;
    wire rd_cmd;
    wire [7:0] rd_val;
    // next values of the flags and of the line
    reg nxt_rx_ready_flag;
    reg nxt_tx_done_flag;
    reg nxt_retry_limit_flag;
    reg nxt_irq_n;

    // register commands carry 00 in the top two bits; other opcodes belong to
    // the payload and fifo commands, which this bank leaves alone
    function is_reg_cmd;
        input [7:0] cmd;
        begin
            is_reg_cmd = (cmd[`RDIRQ_CMD_OP_MSB:`RDIRQ_CMD_OP_LSB] == `RDIRQ_CMD_OP_REG);
        end
    endfunction

    // edges are taken only from the second and third stages; the first stage
    // may still be metastable and is read by nothing but the second
    assign cs_fall = cs_s3_ff & ~cs_s2_ff;
    assign cs_active = ~cs_s2_ff;
    assign sck_rise = sck_s2_ff & ~sck_s3_ff & cs_active;
    assign sck_fall = ~sck_s2_ff & sck_s3_ff & cs_active;
    // the incoming bit joins the shift register on the same sck rise that counts it
    assign rx_byte = {rx_sr_ff[6:0], mosi_s2_ff};
    assign byte_done = sck_rise & (bit_cnt_ff == 3'h7);
    // only the first data byte after a register-write command lands
    assign wr_stb = byte_done & (byte_cnt_ff == 2'h1) & is_reg_cmd(cmd_ff)
                    & cmd_ff[`RDIRQ_CMD_WRITE_BIT];
    // a read command answers with one register byte after the status byte
    assign rd_cmd = is_reg_cmd(cmd_ff) & ~cmd_ff[`RDIRQ_CMD_WRITE_BIT];
    // auto ack on any pipe overrides a cleared crc enable; the stored bit is
    // kept, so clearing every auto ack brings the written value back
    assign crc_en_eff = crc_en_ff | (|auto_ack_ff);
    // status byte: top and bottom bits are unused and read zero
    assign status_val = {1'b0, rx_ready_flag_ff, tx_done_flag_ff, retry_limit_flag_ff,
                         pipe_ff, 1'b0};

    // read mux: unmapped addresses and undefined bits return zero
    // config bit 3 shows the forced value, not the stored one
    function [7:0] rd_mux;
        input [4:0] addr;
        begin
            case (addr)
                `RDIRQ_ADDR_CONFIG: rd_mux = {1'b0, mask_rx_ready_ff, mask_tx_done_ff,
                                              mask_retry_limit_ff, crc_en_eff,
                                              crc_length_sel_ff, power_on_bit_ff,
                                              primary_role_sel_ff};
                `RDIRQ_ADDR_AUTO_ACK: rd_mux = {2'h0, auto_ack_ff};
                `RDIRQ_ADDR_RX_EN: rd_mux = {2'h0, rx_enable_ff};
                `RDIRQ_ADDR_STATUS: rd_mux = status_val;
                default: rd_mux = 8'h00;
            endcase
        end
    endfunction

    // read data is taken at the byte boundary, so a flag that sets during the
    // data byte shows up only on the next read
    assign rd_val = rd_mux(cmd_ff[4:0]);

    // flag update: a hardware event in the clear cycle wins over the clear
    // so that an event can never be lost to a write-one-to-clear racing it
    always @* begin
        nxt_rx_ready_flag = rx_ready_flag_ff;
        nxt_tx_done_flag = tx_done_flag_ff;
        nxt_retry_limit_flag = retry_limit_flag_ff;
        if (wr_stb && (cmd_ff[4:0] == `RDIRQ_ADDR_STATUS)) begin
            nxt_rx_ready_flag = rx_ready_flag_ff & ~rx_byte[`RDIRQ_BIT_RX_READY];
            nxt_tx_done_flag = tx_done_flag_ff & ~rx_byte[`RDIRQ_BIT_TX_DONE];
            nxt_retry_limit_flag = retry_limit_flag_ff & ~rx_byte[`RDIRQ_BIT_RETRY];
        end
        nxt_rx_ready_flag = nxt_rx_ready_flag | rx_ready_evt_i;
        nxt_tx_done_flag = nxt_tx_done_flag | tx_done_evt_i;
        nxt_retry_limit_flag = nxt_retry_limit_flag | retry_limit_evt_i;
        // low while any unmasked flag stands
        nxt_irq_n = ~((nxt_rx_ready_flag & ~mask_rx_ready_ff)
                    | (nxt_tx_done_flag & ~mask_tx_done_ff)
                    | (nxt_retry_limit_flag & ~mask_retry_limit_ff));
    end

    // pin synchronisers; idle levels keep the port quiet out of reset, so no
    // false select or clock edge is seen on the first cycles after release.
    // the host must hold sck high and low for at least four clocks each
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cs_s1_ff <= 1'b1;
            cs_s2_ff <= 1'b1;
            cs_s3_ff <= 1'b1;
            sck_s1_ff <= 1'b0;
            sck_s2_ff <= 1'b0;
            sck_s3_ff <= 1'b0;
            mosi_s1_ff <= 1'b0;
            mosi_s2_ff <= 1'b0;
        end else if (ce_i) begin
            cs_s1_ff <= chip_select_n_i;
            cs_s2_ff <= cs_s1_ff;
            cs_s3_ff <= cs_s2_ff;
            sck_s1_ff <= spi_sck_i;
            sck_s2_ff <= sck_s1_ff;
            sck_s3_ff <= sck_s2_ff;
            mosi_s1_ff <= spi_mosi_i;
            mosi_s2_ff <= mosi_s1_ff;
        end
    end

    // serial engine: sample on rising sck, shift out on falling sck (mode 0)
    // frames longer than two bytes are tolerated: extra bytes read as zero
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bit_cnt_ff <= 3'h0;
            byte_cnt_ff <= 2'h0;
            rx_sr_ff <= 8'h00;
            tx_sr_ff <= 8'h00;
            cmd_ff <= 8'h00;
            spi_miso_o <= 1'b0;
        end else if (ce_i) begin
            if (cs_fall) begin
                // a select edge restarts the frame even if the last one was cut short
                // status goes out first so the host sees flags on every command
                bit_cnt_ff <= 3'h0;
                byte_cnt_ff <= 2'h0;
                spi_miso_o <= status_val[7];
                tx_sr_ff <= {status_val[6:0], 1'b0};
            end else if (!cs_active) begin
                // idle between frames: counters wait at zero
                bit_cnt_ff <= 3'h0;
                byte_cnt_ff <= 2'h0;
            end else begin
                if (sck_rise) begin
                    rx_sr_ff <= rx_byte;
                    bit_cnt_ff <= bit_cnt_ff + 3'h1;
                    if (byte_done) begin
                        if (byte_cnt_ff == 2'h0) begin
                            cmd_ff <= rx_byte;
                        end
                        // saturate so later bytes are simply ignored
                        if (byte_cnt_ff != 2'h2) begin
                            byte_cnt_ff <= byte_cnt_ff + 2'h1;
                        end
                    end
                end
                if (sck_fall) begin
                    if (bit_cnt_ff == 3'h0) begin
                        // byte boundary: read data follows a read command, else zeros
                        if ((byte_cnt_ff == 2'h1) && rd_cmd) begin
                            // msb goes out now, the shift register keeps the other seven
                            spi_miso_o <= rd_val[7];
                            tx_sr_ff <= {rd_val[6:0], 1'b0};
                        end else begin
                            spi_miso_o <= 1'b0;
                            tx_sr_ff <= 8'h00;
                        end
                    end else begin
                        spi_miso_o <= tx_sr_ff[7];
                        tx_sr_ff <= {tx_sr_ff[6:0], 1'b0};
                    end
                end
            end
        end
    end

    // configuration registers; reserved bits are simply not stored
    // writes to the test addresses fall through to the default and change nothing
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {mask_rx_ready_ff, mask_tx_done_ff, mask_retry_limit_ff} <= `RDIRQ_RST_MASKS;
            crc_en_ff <= `RDIRQ_RST_CRC_EN;
            crc_length_sel_ff <= `RDIRQ_RST_CRC_LEN;
            power_on_bit_ff <= `RDIRQ_RST_PWR;
            primary_role_sel_ff <= `RDIRQ_RST_PRIM;
            auto_ack_ff <= `RDIRQ_RST_AUTO_ACK;
            rx_enable_ff <= `RDIRQ_RST_RX_EN;
        end else if (ce_i && wr_stb) begin
            case (cmd_ff[4:0])
                `RDIRQ_ADDR_CONFIG: begin
                    mask_rx_ready_ff <= rx_byte[`RDIRQ_BIT_MASK_RX];
                    mask_tx_done_ff <= rx_byte[`RDIRQ_BIT_MASK_TX];
                    mask_retry_limit_ff <= rx_byte[`RDIRQ_BIT_MASK_RT];
                    crc_en_ff <= rx_byte[`RDIRQ_BIT_CRC_EN];
                    crc_length_sel_ff <= rx_byte[`RDIRQ_BIT_CRC_LEN];
                    power_on_bit_ff <= rx_byte[`RDIRQ_BIT_PWR];
                    primary_role_sel_ff <= rx_byte[`RDIRQ_BIT_PRIM];
                end
                `RDIRQ_ADDR_AUTO_ACK: begin
                    auto_ack_ff <= rx_byte[5:0];
                end
                `RDIRQ_ADDR_RX_EN: begin
                    rx_enable_ff <= rx_byte[5:0];
                end
                // test addresses and unmapped ones take no write
                default: begin
                end
            endcase
        end
    end

    // status flags, pipe field and the interrupt line
    // the line is registered so it never glitches while flags and masks change together
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_ready_flag_ff <= 1'b0;
            tx_done_flag_ff <= 1'b0;
            retry_limit_flag_ff <= 1'b0;
            pipe_ff <= `RDIRQ_RST_PIPE;
            radio_irq_n_o <= 1'b1;
        end else if (ce_i) begin
            rx_ready_flag_ff <= nxt_rx_ready_flag;
            tx_done_flag_ff <= nxt_tx_done_flag;
            retry_limit_flag_ff <= nxt_retry_limit_flag;
            radio_irq_n_o <= nxt_irq_n;
            // pipe number is captured only as the line goes low
            // limitation: a source that sets while the line is already low keeps the old pipe
            if (radio_irq_n_o && !nxt_irq_n) begin
                pipe_ff <= rx_pipe_i;
            end
        end
    end

    // configuration outputs mirror the stored fields
    // one cycle behind the registers; crc enable already carries the auto ack override
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            crc_enable_o <= `RDIRQ_RST_CRC_EN;
            crc_length_sel_o <= `RDIRQ_RST_CRC_LEN;
            power_on_bit_o <= `RDIRQ_RST_PWR;
            primary_role_sel_o <= `RDIRQ_RST_PRIM;
            auto_ack_o <= `RDIRQ_RST_AUTO_ACK;
            rx_enable_o <= `RDIRQ_RST_RX_EN;
        end else if (ce_i) begin
            crc_enable_o <= crc_en_eff;
            crc_length_sel_o <= crc_length_sel_ff;
            power_on_bit_o <= power_on_bit_ff;
            primary_role_sel_o <= primary_role_sel_ff;
            auto_ack_o <= auto_ack_ff;
            rx_enable_o <= rx_enable_ff;
        end
    end
endmodule // rdirq_bank
`default_nettype wire

// [rdirq_host.sv]
// host model: serial register master for the radio irq/config bank
`timescale 1ns/1ps
`default_nettype none
module rdirq_host (
    input wire logic clock_i,
    input wire logic miso_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic mosi_o
);
    // mode 0 idle: select high, serial clock low
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        mosi_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #2;
    endtask
    // command byte then data byte, msb first, 200 ns per bit; the host talks only
    // through these register commands and never aims at the test addresses
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [15:0] sh);
        logic [15:0] fr;
        fr = {cmd, wd};
        cs_n_o = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi_o = fr[i];
            tick(4);
            sck_o = 1'b1;
            sh = {sh[14:0], miso_i}; // taken on the rising serial edge
            tick(4);
            sck_o = 1'b0;
        end
        tick(4);
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o; // released line must not show the last bit
        tick(8); // gap long enough for the select synchroniser
    endtask
endmodule // rdirq_host
`default_nettype wire

// [rdirq_bank_properties.sv]
// port-level checks of the radio irq/config bank
`timescale 1ns/1ps
`default_nettype none
module rdirq_bank_properties (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic chip_select_n_i,
    input wire logic spi_sck_i,
    input wire logic spi_mosi_i,
    input wire logic spi_miso_o,
    input wire logic tx_done_evt_i,
    input wire logic rx_ready_evt_i,
    input wire logic retry_limit_evt_i,
    input wire logic [2:0] rx_pipe_i,
    input wire logic radio_irq_n_o,
    input wire logic crc_enable_o,
    input wire logic crc_length_sel_o,
    input wire logic power_on_bit_o,
    input wire logic primary_role_sel_o,
    input wire logic [5:0] auto_ack_o,
    input wire logic [5:0] rx_enable_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    // any event pulse; a host write may also unmask a pending flag
    wire logic evt = tx_done_evt_i | rx_ready_evt_i | retry_limit_evt_i;
    property p_irq_fall; $fell(radio_irq_n_o) |-> $past(evt) || !$past(chip_select_n_i, 2); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without a cause");
    property p_irq_rise; $rose(radio_irq_n_o) |-> !$past(chip_select_n_i, 2); endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq released without a host write");
    property p_irq_holds; !radio_irq_n_o && chip_select_n_i && $past(chip_select_n_i, 3) |=> !radio_irq_n_o; endproperty
    a_irq_holds: assert property (p_irq_holds) else $error("irq left low level on its own");
    property p_crc_forced; (|auto_ack_o) |-> crc_enable_o; endproperty
    a_crc_forced: assert property (p_crc_forced) else $error("crc off with auto ack on");
    // checked on the second reset edge, once the asynchronous clear has landed
    property p_reset; disable iff (1'b0) (!rstn_i ##1 !rstn_i) |-> radio_irq_n_o && crc_enable_o
        && auto_ack_o == 6'h3F && rx_enable_o == 6'h03 && !power_on_bit_o
        && !primary_role_sel_o && !crc_length_sel_o; endproperty
    a_reset: assert property (p_reset) else $error("wrong levels in reset");
    property p_cfg_cause; !$stable({power_on_bit_o, primary_role_sel_o, crc_length_sel_o, rx_enable_o})
        |-> !$past(chip_select_n_i, 3); endproperty
    a_cfg_cause: assert property (p_cfg_cause) else $error("config moved outside a command");
    property p_status_first; $fell(chip_select_n_i) |-> ##4 !spi_miso_o; endproperty
    a_status_first: assert property (p_status_first) else $error("first serial bit not zero");
    property p_miso_stands; spi_sck_i && $past(spi_sck_i) |-> $stable(spi_miso_o); endproperty
    a_miso_stands: assert property (p_miso_stands) else $error("serial out moved with clock high");
endmodule // rdirq_bank_properties
bind rdirq_bank rdirq_bank_properties rdirq_bank_properties_inst (.*);
`default_nettype wire

// [tb.sv]
// self-checking bench for the radio irq/config bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [2:0] evt = 3'h0; // {rx ready, tx done, retry limit}
    logic [2:0] pipe = 3'h5;
    logic [15:0] sh;
    logic [7:0] st_exp;
    logic ce = 1'b1;
    wire cs_n, sck, mosi, miso, irq_n, crc_en, crc_len, pwr, role;
    wire [5:0] aa, rxe;
    int n_fail = 0;
    int checked = 0;
    // rows: write?, address, write data, read-back, {crc en, crc len, power, role}
    logic [25:0] rows [13] = '{{1'h0, 5'h00, 8'h00, 8'h08, 4'h8}, {1'h0, 5'h01, 8'h00, 8'h3F, 4'h8},
        {1'h0, 5'h02, 8'h00, 8'h03, 4'h8}, {1'h0, 5'h07, 8'h00, 8'h0E, 4'h8},
        {1'h1, 5'h00, 8'hFF, 8'h7F, 4'hF}, {1'h1, 5'h01, 8'hFF, 8'h3F, 4'hF},
        {1'h1, 5'h02, 8'hC5, 8'h05, 4'hF}, {1'h1, 5'h01, 8'h00, 8'h00, 4'hF},
        {1'h1, 5'h00, 8'h77, 8'h77, 4'h7}, {1'h1, 5'h05, 8'h55, 8'h00, 4'h7},
        {1'h1, 5'h01, 8'h21, 8'h21, 4'hF}, {1'h0, 5'h00, 8'h00, 8'h7F, 4'hF},
        {1'h1, 5'h00, 8'h0B, 8'h0B, 4'hB}};
    rdirq_bank rdirq_bank_inst (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce),
        .chip_select_n_i(cs_n), .spi_sck_i(sck), .spi_mosi_i(mosi), .spi_miso_o(miso),
        .tx_done_evt_i(evt[1]), .rx_ready_evt_i(evt[2]), .retry_limit_evt_i(evt[0]),
        .rx_pipe_i(pipe), .radio_irq_n_o(irq_n), .crc_enable_o(crc_en),
        .crc_length_sel_o(crc_len), .power_on_bit_o(pwr), .primary_role_sel_o(role),
        .auto_ack_o(aa), .rx_enable_o(rxe));
    rdirq_host rdirq_host_inst (.clock_i(clock_i), .miso_i(miso), .cs_n_o(cs_n), .sck_o(sck),
        .mosi_o(mosi));
    // 40 MHz clock
    initial forever #12.5 clock_i = ~clock_i;
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #2;
    endtask
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        rdirq_host_inst.xfer({3'h1, a}, d, sh);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e, input string nm);
        rdirq_host_inst.xfer({3'h0, a}, 8'h00, sh);
        check(nm, sh[7:0], e);
    endtask
    // one-cycle event pulse; flag and registered irq update on the same edge, then one idle cycle
    task automatic pulse(input logic [2:0] v);
        evt = v;
        tick(1);
        evt = 3'h0;
        tick(1);
    endtask
    task automatic final_report;
        if (n_fail == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // main sequence; status is only read once the irq fall has settled
    initial begin
        tick(10);
        rstn_i = 1'b1;
        tick(4);
        foreach (rows[i]) begin
            if (rows[i][25])
                wr(rows[i][24:20], rows[i][19:12]);
            rd(rows[i][24:20], rows[i][11:4], "readback");
            check("status first", sh[15:8], 8'h0E);
            check("pins", {4'h0, crc_en, crc_len, pwr, role}, {4'h0, rows[i][3:0]});
        end
        check("auto ack", {2'h0, aa}, 8'h21);
        check("rx enables", {2'h0, rxe}, 8'h05);
        // each source in turn: raise, read pipe captured at the fall, clear by writing one
        for (int k = 0; k < 3; k++) begin
            pipe = k[2:0] + 3'h1;
            pulse(3'h1 << k);
            pipe = 3'h0; // a later pipe change must not reach the field
            check("irq low", {7'h0, irq_n}, 8'h00);
            st_exp = (8'h10 << k) | {4'h0, k[2:0] + 3'h1, 1'h0};
            rd(5'h07, st_exp, "status");
            check("status lead", sh[15:8], st_exp);
            wr(5'h07, 8'h10 << k);
            check("irq cleared", {7'h0, irq_n}, 8'h01);
        end
        // rx masked, tx and rx together: tx alone holds the line until cleared
        wr(5'h00, 8'h4B);
        pulse(3'h6);
        check("irq tx", {7'h0, irq_n}, 8'h00);
        wr(5'h07, 8'h20);
        check("irq masked rx", {7'h0, irq_n}, 8'h01);
        rd(5'h07, 8'h40, "status masked");
        pipe = 3'h6;
        wr(5'h00, 8'h0B);
        check("irq unmasked", {7'h0, irq_n}, 8'h00);
        rd(5'h07, 8'h4C, "status unmasked");
        wr(5'h07, 8'h40);
        check("irq final", {7'h0, irq_n}, 8'h01);
        // second reset in mid-run
        rstn_i = 1'b0;
        tick(2);
        check("reset auto ack", {2'h0, aa}, 8'h3F);
        rstn_i = 1'b1;
        tick(4);
        rd(5'h00, 8'h08, "config reset");
        rd(5'h02, 8'h03, "rx enables reset");
        // frozen: an event pulse while the clock enable is low leaves no flag behind
        ce = 1'b0;
        pulse(3'h7);
        ce = 1'b1;
        tick(2);
        check("irq frozen", {7'h0, irq_n}, 8'h01);
        rd(5'h07, 8'h0E, "status frozen");
        final_report;
    end
endmodule // tb
`default_nettype wire
